// ===== src/ousb_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ousb_regs (
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_reset_n,
   // register access
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [5:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   output var  logic [7:0] o_reg_rdata,
   output var  logic       o_reg_rvalid,
   // comparator sources, async
   input  wire logic       i_host_disconnect,
   input  wire logic       i_vbus_valid_cmp,
   input  wire logic       i_sess_valid,
   input  wire logic       i_sess_end,
   input  wire logic       i_id_gnd,
   input  wire logic       i_host_mode,
   // analog controls and event pending flag
   output var  logic       o_id_pin_pullup_en,
   output var  logic       o_dplus_pulldown_en,
   output var  logic       o_dminus_pulldown_en,
   output var  logic       o_vbus_discharge_en,
   output var  logic       o_vbus_charge_en,
   output var  logic       o_event_pending
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [5:0] src_sync;
   ousb_sync #(.WIDTH(6)) u_sync (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .i_async   ({i_host_mode, i_id_gnd, i_sess_end, i_sess_valid,
                   i_vbus_valid_cmp, i_host_disconnect}),
      .o_sync    (src_sync)
   );
   // ----------------------------------------
   // control registers
   // ----------------------------------------
   function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
      hit = (a == b);
   endfunction
   logic [7:0] otg_q;
   logic [4:0] rise_q;
   logic [4:0] fall_q;
   ousb_wsc #(.WIDTH(8), .RESET(ousb_pkg::OTG_RESET)) u_otg (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .i_wr      (i_reg_wr && hit(i_reg_addr, ousb_pkg::OTG_WR)),
      .i_set     (i_reg_wr && hit(i_reg_addr, ousb_pkg::OTG_SET)),
      .i_clr     (i_reg_wr && hit(i_reg_addr, ousb_pkg::OTG_CLR)),
      .i_data    (i_reg_wdata),
      .o_value   (otg_q)
   );
   ousb_wsc #(.WIDTH(5), .RESET(ousb_pkg::EN_RESET)) u_rise (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .i_wr      (i_reg_wr && hit(i_reg_addr, ousb_pkg::RISE_WR)),
      .i_set     (i_reg_wr && hit(i_reg_addr, ousb_pkg::RISE_SET)),
      .i_clr     (i_reg_wr && hit(i_reg_addr, ousb_pkg::RISE_CLR)),
      .i_data    (i_reg_wdata[4:0]),
      .o_value   (rise_q)
   );
   ousb_wsc #(.WIDTH(5), .RESET(ousb_pkg::EN_RESET)) u_fall (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .i_wr      (i_reg_wr && hit(i_reg_addr, ousb_pkg::FALL_WR)),
      .i_set     (i_reg_wr && hit(i_reg_addr, ousb_pkg::FALL_SET)),
      .i_clr     (i_reg_wr && hit(i_reg_addr, ousb_pkg::FALL_CLR)),
      .i_data    (i_reg_wdata[4:0]),
      .o_value   (fall_q)
   );
   // ----------------------------------------
   // live status and edge latch
   // ----------------------------------------
   localparam logic ext_vbus_indicator_in = 1'b1;
   logic [4:0] live;
   logic [4:0] prev_q;
   logic [4:0] latch_q;
   logic [4:0] latch_d;
   logic [4:0] evt;
   logic [2:0] prim_q;
   logic       rd_latch;
   logic [7:0] rdata_d;
   logic [4:0] ctl_d;
   always_comb begin
      live = src_sync[4:0];
      if (otg_q[ousb_pkg::BIT_SELEXT]) begin
         live[ousb_pkg::BIT_VBUSVAL] = ext_vbus_indicator_in;
      end
      evt = (live & ~prev_q & rise_q) | (~live & prev_q & fall_q);
      if (!src_sync[5]) begin
         evt[ousb_pkg::BIT_HOSTDISC] = 1'b0;
      end
      if (!prim_q[2]) begin
         evt = '0;
      end
      rd_latch = i_reg_rd && hit(i_reg_addr, ousb_pkg::LATCH_ADDR);
      latch_d = latch_q;
      if (rd_latch) begin
         latch_d = '0;
      end
      latch_d = latch_d | evt;                                      // set wins
      rdata_d = 8'h00;
      if (i_reg_addr >= ousb_pkg::OTG_WR && i_reg_addr <= ousb_pkg::OTG_CLR) begin
         rdata_d = otg_q;
      end else if (i_reg_addr >= ousb_pkg::RISE_WR && i_reg_addr <= ousb_pkg::RISE_CLR) begin
         rdata_d = {3'h0, rise_q};
      end else if (i_reg_addr >= ousb_pkg::FALL_WR && i_reg_addr <= ousb_pkg::FALL_CLR) begin
         rdata_d = {3'h0, fall_q};
      end else if (hit(i_reg_addr, ousb_pkg::STATUS_ADDR)) begin
         rdata_d = {3'h0, live};
      end else if (hit(i_reg_addr, ousb_pkg::LATCH_ADDR)) begin
         rdata_d = {3'h0, latch_q};
      end
      ctl_d = otg_q[4:0];
   end
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         prev_q               <= '0;
         prim_q               <= '0;
         latch_q              <= '0;
         o_reg_rdata          <= 8'h00;
         o_reg_rvalid         <= 1'b0;
         o_id_pin_pullup_en   <= 1'b0;
         o_dplus_pulldown_en  <= 1'b1;
         o_dminus_pulldown_en <= 1'b1;
         o_vbus_discharge_en  <= 1'b0;
         o_vbus_charge_en     <= 1'b0;
         o_event_pending      <= 1'b0;
      end else begin
         prev_q               <= live;
         prim_q               <= {prim_q[1:0], 1'b1};
         latch_q              <= latch_d;
         o_reg_rdata          <= i_reg_rd ? rdata_d : 8'h00;
         o_reg_rvalid         <= i_reg_rd;
         o_id_pin_pullup_en   <= ctl_d[0];
         o_dplus_pulldown_en  <= ctl_d[1];
         o_dminus_pulldown_en <= ctl_d[2];
         o_vbus_discharge_en  <= ctl_d[3];
         o_vbus_charge_en     <= ctl_d[4];
         o_event_pending      <= |latch_d;
      end
   end
endmodule
`default_nettype wire

// ===== src/ousb_pkg.sv
package ousb_pkg;
   localparam logic [5:0] OTG_WR      = 6'h0a;
   localparam logic [5:0] OTG_SET     = 6'h0b;
   localparam logic [5:0] OTG_CLR     = 6'h0c;
   localparam logic [5:0] RISE_WR     = 6'h0d;
   localparam logic [5:0] RISE_SET    = 6'h0e;
   localparam logic [5:0] RISE_CLR    = 6'h0f;
   localparam logic [5:0] FALL_WR     = 6'h10;
   localparam logic [5:0] FALL_SET    = 6'h11;
   localparam logic [5:0] FALL_CLR    = 6'h12;
   localparam logic [5:0] STATUS_ADDR = 6'h13;
   localparam logic [5:0] LATCH_ADDR  = 6'h14;
   localparam logic [7:0] OTG_RESET   = 8'h06;
   localparam logic [4:0] EN_RESET    = 5'h1f;
   localparam int         SRC_N       = 5;
   localparam int         BIT_HOSTDISC = 0;
   localparam int         BIT_VBUSVAL  = 1;
   localparam int         BIT_SELEXT   = 7;
endpackage

// ===== src/ousb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ousb_sync #(
   parameter int WIDTH = 5
) (
   input  wire logic             i_clock,
   input  wire logic             i_reset_n,
   input  wire logic [WIDTH-1:0] i_async,
   output var  logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== src/ousb_wsc.sv
`timescale 1ns/1ps
`default_nettype none
module ousb_wsc #(
   parameter int               WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET = '0
) (
   input  wire logic             i_clock,
   input  wire logic             i_reset_n,
   // access strobes
   input  wire logic             i_wr,
   input  wire logic             i_set,
   input  wire logic             i_clr,
   input  wire logic [WIDTH-1:0] i_data,
   // stored value
   output var  logic [WIDTH-1:0] o_value
);
   logic [WIDTH-1:0] val_d;
   always_comb begin
      val_d = o_value;
      if (i_wr) begin
         val_d = i_data;
      end else if (i_set) begin
         val_d = o_value | i_data;
      end else if (i_clr) begin
         val_d = o_value & ~i_data;
      end
   end
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_value <= RESET;
      end else begin
         o_value <= val_d;
      end
   end
endmodule
`default_nettype wire

// ===== verification/ousb_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ousb_monitor (
   input wire logic       i_clock, i_reset_n, i_reg_wr, i_reg_rd, o_reg_rvalid,
   input wire logic [5:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata, o_reg_rdata,
   input wire logic       i_host_disconnect, i_vbus_valid_cmp, i_sess_valid, i_sess_end,
   input wire logic       i_id_gnd, i_host_mode, o_event_pending, o_id_pin_pullup_en,
   input wire logic       o_dplus_pulldown_en, o_dminus_pulldown_en, o_vbus_discharge_en,
   input wire logic       o_vbus_charge_en
);
   wire logic [5:0] srcs = {i_host_mode, i_id_gnd, i_sess_end, i_sess_valid, i_vbus_valid_cmp,
                            i_host_disconnect};
   wire logic [7:0] pins = {3'h0, o_vbus_charge_en, o_vbus_discharge_en, o_dminus_pulldown_en,
                            o_dplus_pulldown_en, o_id_pin_pullup_en};
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   sequence s_wr(a, c);
      i_reg_wr && i_reg_addr == a && c;
   endsequence
   sequence s_rd_quiet(a);
      $stable(srcs) [*5] ##0 i_reg_rd && i_reg_addr == a ##1 $stable(srcs);
   endsequence
   a_read_answer: assert property (
      i_reg_rd |=> o_reg_rvalid) else $error("read got no answer");
   a_answer_cause: assert property (
      o_reg_rvalid |-> $past(i_reg_rd)) else $error("answer without read");
   a_top_bits_zero: assert property (
      i_reg_rd && i_reg_addr > 6'h0c |=> o_reg_rdata[7:5] == 3'h0) else $error("top bits set");
   a_otg_write: assert property (
      s_wr(ousb_pkg::OTG_WR, 1'b1) |-> ##2 pins == ($past(i_reg_wdata, 2) & 8'h1f))
      else $error("pins differ from write");
   a_otg_set: assert property (
      s_wr(ousb_pkg::OTG_SET, i_reg_wdata[0]) |-> ##2 o_id_pin_pullup_en)
      else $error("set missed pull-up");
   a_otg_clear: assert property (
      s_wr(ousb_pkg::OTG_CLR, i_reg_wdata[4]) |-> ##2 !o_vbus_charge_en)
      else $error("clear missed charge");
   a_status_live: assert property (
      s_rd_quiet(ousb_pkg::STATUS_ADDR) |-> {o_reg_rdata[4:2], o_reg_rdata[0]} ==
      {srcs[4:2], srcs[0]}) else $error("status not live");
   a_latch_clears: assert property (
      s_rd_quiet(ousb_pkg::LATCH_ADDR) |-> !o_event_pending) else $error("latch not cleared");
endmodule
bind ousb_regs ousb_monitor mon (.*);
`default_nettype wire

// ===== verification/ousb_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module ousb_link_model (
   input  wire logic       i_clock,
   output var  logic       o_wr,
   output var  logic       o_rd,
   output var  logic [5:0] o_addr,
   output var  logic [7:0] o_wdata,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rvalid
);
   initial o_wr = 1'b0;
   initial o_rd = 1'b0;
   initial o_addr = 6'h00;
   initial o_wdata = 8'h00;
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clock);
      o_wr <= 1'b0;
      o_wdata <= ~d;
      repeat (4) @(posedge i_clock);
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
      @(posedge i_clock);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clock);
      o_rd <= 1'b0;
      @(posedge i_clock);
      d = i_rdata;
      v = i_rvalid;
   endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {logic [5:0] wa; logic [7:0] wd; logic [5:0] ra;
                   logic [7:0] ex; logic [4:0] px;} ousb_row_t;
   logic       clk, rst_n, wr, rd, rvalid, pend;
   logic [5:0] srcs, addr;
   logic [7:0] wdata, rdata, got;
   wire  [4:0] pins;
   int         err_total, n_compared;
   ousb_row_t  rows [12] = '{
      '{6'h0a, 8'hff, 6'h0a, 8'hff, 5'h1f}, '{6'h0c, 8'h81, 6'h0b, 8'h7e, 5'h1e},
      '{6'h0b, 8'h01, 6'h0c, 8'h7f, 5'h1f}, '{6'h0a, 8'h00, 6'h0a, 8'h00, 5'h00},
      '{6'h0d, 8'hff, 6'h0d, 8'h1f, 5'h00}, '{6'h0f, 8'h05, 6'h0e, 8'h1a, 5'h00},
      '{6'h0e, 8'h05, 6'h0f, 8'h1f, 5'h00}, '{6'h10, 8'he0, 6'h10, 8'h00, 5'h00},
      '{6'h11, 8'h1f, 6'h11, 8'h1f, 5'h00}, '{6'h12, 8'h08, 6'h12, 8'h17, 5'h00},
      '{6'h13, 8'hff, 6'h13, 8'h00, 5'h00}, '{6'h3f, 8'hff, 6'h3f, 8'h00, 5'h00}};
   ousb_link_model link (.i_clock(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
                         .i_rdata(rdata), .i_rvalid(rvalid));
   ousb_regs dut (.i_clock(clk), .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_host_disconnect(srcs[0]), .i_vbus_valid_cmp(srcs[1]), .i_sess_valid(srcs[2]),
      .i_sess_end(srcs[3]), .i_id_gnd(srcs[4]), .i_host_mode(srcs[5]),
      .o_id_pin_pullup_en(pins[0]), .o_dplus_pulldown_en(pins[1]),
      .o_dminus_pulldown_en(pins[2]), .o_vbus_discharge_en(pins[3]),
      .o_vbus_charge_en(pins[4]), .o_event_pending(pend));
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdc(input logic [5:0] a, input logic [7:0] e);
      logic v;
      link.rd(a, got, v);
      cmp("rvalid", 8'h01, {7'h00, v});
      cmp($sformatf("reg %h", a), e, got);
   endtask
   task automatic src(input logic [5:0] v);
      srcs <= v;
      repeat (6) @(posedge clk);
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      end_of_test;
   end
   initial begin
      rst_n = 1'b0;
      srcs = 6'h00;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         link.wr(rows[i].wa, rows[i].wd);
         rdc(rows[i].ra, rows[i].ex);
         cmp("pins", {3'h0, rows[i].px}, {3'h0, pins});
      end
      $display("test table done");
      rdc(6'h14, 8'h02);
      src(6'h04);
      rdc(6'h13, 8'h04);
      rdc(6'h14, 8'h04);
      rdc(6'h14, 8'h00);
      cmp("pending", 8'h00, {7'h00, pend});
      src(6'h0c);
      cmp("pending", 8'h01, {7'h00, pend});
      link.wr(6'h14, 8'h00);
      rdc(6'h14, 8'h08);
      src(6'h04);
      rdc(6'h14, 8'h00);
      src(6'h01);
      rdc(6'h14, 8'h04);
      rdc(6'h13, 8'h01);
      src(6'h21);
      src(6'h20);
      rdc(6'h14, 8'h01);
      $display("test events done");
      link.wr(6'h0b, 8'h80);
      rdc(6'h13, 8'h02);
      rdc(6'h14, 8'h02);
      link.wr(6'h0c, 8'h80);
      src(6'h22);
      rdc(6'h13, 8'h02);
      rdc(6'h14, 8'h02);
      $display("test select done");
      src(6'h10);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(6'h13, 8'h10);
      rdc(6'h14, 8'h00);
      rdc(6'h0c, 8'h06);
      rdc(6'h0e, 8'h1f);
      rdc(6'h12, 8'h1f);
      cmp("pins", 8'h06, {3'h0, pins});
      $display("test reset done");
      end_of_test;
   end
endmodule
`default_nettype wire
